// ### rr_exec_pkg.sv
// Constants and types shared by the return and rotate execution block
package rr_exec_pkg;
    localparam int PC_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int TOP_BIT = 7;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 12'h004;
    localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
    localparam logic GATE_RESET = 1'b0;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_RET_IMM = 2'b01,
        OP_RETURN_FROM_INTERRUPT_OP = 2'b10,
        OP_ROTL = 2'b11
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ROT_READ = 2'b01,
        ST_ROT_WRITE = 2'b10
    } state_t;
endpackage : rr_exec_pkg

// ### rr_dmem_if.sv
// Data memory access signals between the executer and its rotate unit
`timescale 1ns/1ps
`default_nettype none
interface rr_dmem_if;
    import rr_exec_pkg::*;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] wr_data;
    modport exec (output rd_data, input wr_data);
    modport rot (input rd_data, output wr_data);
endinterface : rr_dmem_if
`default_nettype wire

// ### rr_rotate_unit.sv
// One-bit left rotate of a data memory byte
`timescale 1ns/1ps
`default_nettype none
module rr_rotate_unit
    import rr_exec_pkg::*;
(
    rr_dmem_if.rot mem
);
    // Bit i moves to i+1; old top bit wraps to bit 0
    genvar i;
    generate
        for (i = 0; i < TOP_BIT; i++) begin : g_shift
            assign mem.wr_data[i+1] = mem.rd_data[i];
        end
    endgenerate
    assign mem.wr_data[0] = mem.rd_data[TOP_BIT];
endmodule : rr_rotate_unit
`default_nettype wire

// ### return_and_rotate_exec.sv
// Execution of return-with-immediate, interrupt return and rotate left
`timescale 1ns/1ps
`default_nettype none
module return_and_rotate_exec
    import rr_exec_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Decoded instruction
    input wire logic op_valid_i,
    input wire logic [1:0] op_i,
    input wire logic [DATA_W-1:0] imm_i,
    input wire logic [ADDR_W-1:0] mem_addr_i,
    // Return stack
    input wire logic [PC_W-1:0] stack_top_i,
    output logic stack_pop_o,
    output logic stack_push_o,
    output logic [PC_W-1:0] stack_push_data_o,
    // Program counter
    input wire logic [PC_W-1:0] pc_i,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_value_o,
    // Interrupts
    input wire logic irq_pending_i,
    input wire logic gate_clear_i,
    output logic global_irq_gate_o,
    output logic irq_ack_o,
    // Work register
    output logic [DATA_W-1:0] work_register_o,
    output logic work_load_o,
    // Data memory
    input wire logic [DATA_W-1:0] mem_rdata_i,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [DATA_W-1:0] mem_wdata_o,
    // Status
    output logic busy_o,
    output logic flags_we_o
);
    state_t state;
    state_t next_state;
    logic gate;
    logic [DATA_W-1:0] work;
    logic busy;
    rr_dmem_if dmem ();

    assign dmem.rd_data = mem_rdata_i;
    rr_rotate_unit u_rot (.mem(dmem));

    wire logic idle = (state == ST_IDLE);
    wire logic do_ret_imm = idle && op_valid_i && (op_i == OP_RET_IMM);
    wire logic do_return_from_interrupt_op = idle && op_valid_i && (op_i == OP_RETURN_FROM_INTERRUPT_OP);
    wire logic do_rotl = idle && op_valid_i && (op_i == OP_ROTL);
    // Interrupt entry only while the gate is set; return_from_interrupt_op counts as setting it
    wire logic gate_eff = gate || do_return_from_interrupt_op;
    wire logic take_irq = idle && irq_pending_i && gate_eff && !(op_valid_i && !do_return_from_interrupt_op);
    // Pending irq at return_from_interrupt_op: restored PC is pushed back and the vector is taken first
    wire logic return_from_interrupt_op_to_irq = do_return_from_interrupt_op && take_irq;
    wire logic irq_only = take_irq && !do_return_from_interrupt_op;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (do_rotl) next_state = ST_ROT_READ;
            end
            ST_ROT_READ: next_state = ST_ROT_WRITE;
            ST_ROT_WRITE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Busy is held in its own flop so the output never glitches on a state change
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            busy <= 1'b0;
        end else begin
            busy <= (next_state != ST_IDLE);
        end
    end

    // Set by return_from_interrupt_op wins over a clear; entering a routine closes the gate
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gate <= GATE_RESET;
        end else if (return_from_interrupt_op_to_irq || irq_only) begin
            gate <= 1'b0;
        end else if (do_return_from_interrupt_op) begin
            gate <= 1'b1;
        end else if (gate_clear_i) begin
            gate <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            work <= WORK_RESET;
            work_load_o <= 1'b0;
        end else begin
            work_load_o <= do_ret_imm;
            if (do_ret_imm) work <= imm_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            stack_pop_o <= 1'b0;
            stack_push_o <= 1'b0;
            stack_push_data_o <= PC_RESET;
            pc_load_o <= 1'b0;
            pc_value_o <= PC_RESET;
            irq_ack_o <= 1'b0;
        end else begin
            stack_pop_o <= do_ret_imm || do_return_from_interrupt_op;
            stack_push_o <= take_irq;
            stack_push_data_o <= return_from_interrupt_op_to_irq ? stack_top_i : pc_i;
            pc_load_o <= do_ret_imm || do_return_from_interrupt_op || take_irq;
            pc_value_o <= take_irq ? IRQ_VECTOR : stack_top_i;
            irq_ack_o <= take_irq;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            mem_addr_o <= '0;
            mem_wdata_o <= WORK_RESET;
        end else begin
            mem_rd_o <= do_rotl;
            mem_wr_o <= (state == ST_ROT_READ);
            if (do_rotl) mem_addr_o <= mem_addr_i;
            if (state == ST_ROT_READ) mem_wdata_o <= dmem.wr_data;
        end
    end

    // These instructions never write flags; no flag path exists here
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flags_we_o <= 1'b0;
        end else begin
            flags_we_o <= 1'b0;
        end
    end

    assign global_irq_gate_o = gate;
    assign work_register_o = work;
    assign busy_o = busy;

    a_ret_imm_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        do_ret_imm |=> (work == $past(imm_i)) && stack_pop_o && pc_load_o)
        else $error("ret imm did not load work register and pop");
    a_return_from_interrupt_op_gate_set: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (do_return_from_interrupt_op && !take_irq) |=> gate && stack_pop_o && (pc_value_o == $past(stack_top_i)))
        else $error("return_from_interrupt_op did not set gate and restore pc");
    a_gate_blocks_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        irq_ack_o |-> $past(gate) || $past(do_return_from_interrupt_op))
        else $error("interrupt entered with gate clear");
    a_return_from_interrupt_op_pending_vec: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        return_from_interrupt_op_to_irq |=> pc_value_o == IRQ_VECTOR && stack_push_o && stack_push_data_o == $past(stack_top_i))
        else $error("pending irq not serviced at return_from_interrupt_op");
    a_rotl_result: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        do_rotl ##1 1'b1 |=> mem_wr_o && mem_wdata_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])})
        else $error("rotate result wrong");
    a_rotl_sequence: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        do_rotl |=> mem_rd_o ##1 mem_wr_o ##1 !busy_o)
        else $error("rotate sequence wrong");
    a_no_flag_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (do_ret_imm || do_return_from_interrupt_op || do_rotl) |=> !flags_we_o [*3])
        else $error("flags written by return or rotate");
    a_gate_closes_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take_irq |=> !gate)
        else $error("gate still open inside routine");

    // Gate and interrupt entry
    a_gate_clear_works: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (gate_clear_i && !do_return_from_interrupt_op) |=> !gate)
        else $error("gate clear request ignored");
    a_no_irq_gate_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!gate && !do_return_from_interrupt_op) |=> !irq_ack_o)
        else $error("interrupt acknowledged with gate low");
    a_irq_push_pc: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        irq_only |=> stack_push_o && (stack_push_data_o == $past(pc_i)) && (pc_value_o == IRQ_VECTOR))
        else $error("interrupt entry did not push pc and vector");
    a_irq_ack_push: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        irq_ack_o |-> stack_push_o && pc_load_o)
        else $error("interrupt acknowledged without push and load");
    a_return_from_interrupt_op_pend_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        return_from_interrupt_op_to_irq |=> !gate && stack_pop_o && irq_ack_o)
        else $error("return_from_interrupt_op with pending irq left gate open");

    // Returns and work register
    a_pop_from_ret: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        stack_pop_o |-> $past(do_ret_imm || do_return_from_interrupt_op))
        else $error("stack popped without a return");
    a_work_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !do_ret_imm |=> $stable(work))
        else $error("work register changed without ret imm");
    a_ret_no_mem: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (do_ret_imm || do_return_from_interrupt_op) |=> !mem_rd_o && !mem_wr_o)
        else $error("return touched data memory");

    // Rotate
    a_rotl_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        do_rotl |=> (mem_addr_o == $past(mem_addr_i)) && busy_o)
        else $error("rotate address not captured");
    a_wdata_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state != ST_ROT_READ) |=> $stable(mem_wdata_o))
        else $error("write data changed outside rotate");
    a_busy_drops_op: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (busy_o && op_valid_i) |=> !stack_pop_o && !work_load_o && !mem_rd_o)
        else $error("instruction accepted while busy");
endmodule : return_and_rotate_exec
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the return and rotate execution block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rr_exec_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0;
    logic [1:0] op = 2'h0;
    logic [DATA_W-1:0] imm = 8'h00;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [PC_W-1:0] stack_top = 12'h000;
    logic [PC_W-1:0] pc = 12'h000;
    logic irq_pending = 1'b0;
    logic gate_clear = 1'b0;
    logic [DATA_W-1:0] rdata = 8'h00;
    logic pop, push, pc_load, gate, irq_ack, work_load, mem_rd, mem_wr, busy, flags_we;
    logic [PC_W-1:0] push_data, pc_value;
    logic [DATA_W-1:0] work, wdata;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] rot_in [3] = '{8'h95, 8'h80, 8'h01};
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;

    return_and_rotate_exec return_and_rotate_exec_i (
        .clk_sys_i(clk_sys), .rst_i(rst), .op_valid_i(op_valid), .op_i(op), .imm_i(imm),
        .mem_addr_i(addr), .stack_top_i(stack_top), .stack_pop_o(pop), .stack_push_o(push),
        .stack_push_data_o(push_data), .pc_i(pc), .pc_load_o(pc_load), .pc_value_o(pc_value),
        .irq_pending_i(irq_pending), .gate_clear_i(gate_clear), .global_irq_gate_o(gate),
        .irq_ack_o(irq_ack), .work_register_o(work), .work_load_o(work_load),
        .mem_rdata_i(rdata), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_addr_o(mem_addr),
        .mem_wdata_o(wdata), .busy_o(busy), .flags_we_o(flags_we)
    );

    always #12.5 clk_sys = ~clk_sys;

    // A hung handshake must still reach the closing report
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Called and left 2 ns after a rising edge
    task automatic issue(input logic [1:0] code);
        op_valid = 1'b1;
        op = code;
        @(posedge clk_sys);
        #2;
        op_valid = 1'b0;
    endtask : issue

    task automatic t_gate_off();
        check("gate", gate, GATE_RESET);
        irq_pending = 1'b1;
        repeat (4) begin
            @(posedge clk_sys);
            #2;
            check("irq_ack", irq_ack, 1'b0);
        end
        irq_pending = 1'b0;
    endtask : t_gate_off

    task automatic t_ret_imm();
        stack_top = 12'h3A5;
        imm = 8'h5C;
        issue(OP_RET_IMM);
        check("pop", {pop, pc_load, work_load}, 3'b111);
        check("pc_value", pc_value, 12'h3A5);
        check("work", work, 8'h5C);
        @(posedge clk_sys);
        #2;
        stack_top = 12'h7F0;
        imm = 8'hA3;
        issue(OP_RET_IMM);
        check("pc_value", pc_value, 12'h7F0);
        check("work", work, 8'hA3);
        check("flags_we", flags_we, 1'b0);
        @(posedge clk_sys);
        #2;
        check("pop", {pop, pc_load, work_load}, 3'b000);
    endtask : t_ret_imm

    task automatic t_return_from_interrupt_op_plain();
        stack_top = 12'h123;
        issue(OP_RETURN_FROM_INTERRUPT_OP);
        check("pop", {pop, pc_load, irq_ack}, 3'b110);
        check("pc_value", pc_value, 12'h123);
        check("gate", gate, 1'b1);
        check("flags_we", flags_we, 1'b0);
    endtask : t_return_from_interrupt_op_plain

    task automatic t_irq_entry();
        int n;
        pc = 12'h2C8;
        irq_pending = 1'b1;
        for (n = 0; n < 4 && irq_ack !== 1'b1; n++) begin
            @(posedge clk_sys);
            #2;
        end
        irq_pending = 1'b0;
        check("irq_ack", irq_ack, 1'b1);
        check("push_data", push_data, 12'h2C8);
        check("pc_value", pc_value, IRQ_VECTOR);
        check("gate", gate, 1'b0);
    endtask : t_irq_entry

    task automatic t_return_from_interrupt_op_pending();
        @(posedge clk_sys);
        #2;
        stack_top = 12'h456;
        irq_pending = 1'b1;
        issue(OP_RETURN_FROM_INTERRUPT_OP);
        irq_pending = 1'b0;
        check("pop_push_ack", {pop, push, irq_ack}, 3'b111);
        check("push_data", push_data, 12'h456);
        check("pc_value", pc_value, IRQ_VECTOR);
    endtask : t_return_from_interrupt_op_pending

    // Set by return_from_interrupt_op wins over a clear in the same cycle; a clear alone closes the gate
    task automatic t_gate_clear();
        @(posedge clk_sys);
        #2;
        stack_top = 12'h0B7;
        gate_clear = 1'b1;
        issue(OP_RETURN_FROM_INTERRUPT_OP);
        check("gate", gate, 1'b1);
        @(posedge clk_sys);
        #2;
        gate_clear = 1'b0;
        check("gate", gate, 1'b0);
    endtask : t_gate_clear

    task automatic t_rotate();
        @(posedge clk_sys);
        #2;
        for (int i = 0; i < 3; i++) begin
            addr = 8'h42 + 8'(i);
            rdata = rot_in[i];
            op_valid = 1'b1;
            op = OP_ROTL;
            @(posedge clk_sys);
            #2;
            check("rd_busy", {mem_rd, busy}, 2'b11);
            check("mem_addr", mem_addr, 8'h42 + 8'(i));
            // Offered while busy, so it must be dropped
            op = OP_RET_IMM;
            @(posedge clk_sys);
            #2;
            op_valid = 1'b0;
            check("wr", {mem_wr, work_load, flags_we}, 3'b100);
            check("wdata", wdata, {rot_in[i][6:0], rot_in[i][7]});
            @(posedge clk_sys);
            #2;
            check("busy", busy, 1'b0);
        end
    endtask : t_rotate

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    initial begin
        repeat (20) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        t_gate_off();
        t_ret_imm();
        t_return_from_interrupt_op_plain();
        t_irq_entry();
        t_return_from_interrupt_op_pending();
        t_gate_clear();
        t_rotate();
        test_done();
    end
endmodule : testbench
`default_nettype wire
